// ### hw/sfts_pkg.sv
// package: register map, fields and counts of the spi fifo status block
// What this block does
// - tx watermark flag set while tx count is at or below tx threshold
// - rx watermark flag set while rx count exceeds rx threshold
// - irq while tx watermark flag and its enable are both set
// - irq while rx watermark flag and its enable are both set
// - idle flag after 64 sclk (master) or 576 clocks (slave) unread data
// - idle flag clears on rx fifo read or on write-one
// - idle flag reaches irq only when its enable is one
// - word arriving at full rx fifo is dropped and sets sticky overrun
// - overrun reaches irq only when its enable is one
// - tx flush bit empties tx fifo, then self-clears
// - rx flush bit empties rx fifo, then self-clears
// - status shows 4-bit tx fifo count
// - status shows 4-bit rx fifo count
// - status shows full and empty flags, mirrored to main control
// - unit-done sets a mirrored flag cleared by write-one
// - three-wire begin flag set on start, cleared on done or write-one
// - reading rx data returns and removes the oldest entry
package sfts_pkg;
  localparam int DATA_W   = 32;
  localparam int ADDR_W   = 8;
  localparam int DEPTH    = 8;
  localparam int PTR_W    = 3;
  localparam int CNT_W    = 4;
  localparam int TMR_W    = 10;
  // register byte addresses
  localparam logic [7:0] OFF_RXDATA  = 8'h10;
  localparam logic [7:0] OFF_TXDATA  = 8'h20;
  localparam logic [7:0] OFF_CTL     = 8'h40;
  localparam logic [7:0] OFF_STAT    = 8'h44;
  localparam logic [7:0] OFF_EVT     = 8'h48;
  localparam logic [7:0] OFF_EVT_CLR = 8'h4C;
  localparam logic [7:0] OFF_EVT_EN  = 8'h50;
  // reset values
  localparam logic [31:0] RST_CTL  = 32'h44000000;
  localparam logic [31:0] RST_STAT = 32'h05000000;
  // fifo_control fields
  localparam int CTL_TXTHR_LSB = 28;
  localparam int CTL_RXTHR_LSB = 24;
  localparam int CTL_TO_EN     = 21;
  localparam int CTL_OV_EN     = 6;
  localparam int CTL_TX_EN     = 3;
  localparam int CTL_RX_EN     = 2;
  localparam int CTL_TX_FLUSH  = 1;
  localparam int CTL_RX_FLUSH  = 0;
  localparam logic [31:0] CTL_RW_MASK = 32'h7720004C;
  // status fields, also the event register layout
  localparam int ST_TXCNT_LSB = 28;
  localparam int ST_TXFULL    = 27;
  localparam int ST_TXEMPTY   = 26;
  localparam int ST_RXFULL    = 25;
  localparam int ST_RXEMPTY   = 24;
  localparam int ST_TIMEOUT   = 20;
  localparam int ST_UNIT      = 16;
  localparam int ST_RXCNT_LSB = 12;
  localparam int ST_BEGIN     = 11;
  localparam int ST_TXHIT     = 4;
  localparam int ST_OVERRUN   = 2;
  localparam int ST_RXHIT     = 0;
  // idle time-out limits
  localparam logic [9:0] TO_MASTER_SCLK = 10'd64;
  localparam logic [9:0] TO_SLAVE_CLK   = 10'd576;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### hw/sfts_fifo.sv
// module: eight-entry flop fifo with flush, count and flags
`timescale 1ns/100ps
module sfts_fifo (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_nrst,
  input  wire logic                       i_flush,
  input  wire logic                       i_push,
  input  wire logic [sfts_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_pop,
  output logic      [sfts_pkg::DATA_W-1:0] o_head,
  output logic      [sfts_pkg::CNT_W-1:0]  o_count,
  output logic                            o_full,
  output logic                            o_empty
);
  logic [sfts_pkg::DATA_W-1:0] mem [sfts_pkg::DEPTH];
  logic [sfts_pkg::PTR_W-1:0]  wr_ptr;
  logic [sfts_pkg::PTR_W-1:0]  rd_ptr;
  logic [sfts_pkg::CNT_W-1:0]  next_count;
  logic                        do_push;
  logic                        do_pop;

  // pushes at full and pops at empty are dropped
  assign do_push = i_push && !o_full;
  assign do_pop  = i_pop && !o_empty;
  assign o_head  = mem[rd_ptr];

  // count after this cycle's push and pop
  always_comb
  begin
    next_count = o_count;
    if (do_push && !do_pop)
      next_count = o_count + 4'h1;
    else if (do_pop && !do_push)
      next_count = o_count - 4'h1;
  end

  // pointers, count and flags; flush wins over traffic
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_ptr  <= 3'h0;
      rd_ptr  <= 3'h0;
      o_count <= 4'h0;
      o_full  <= 1'b0;
      o_empty <= 1'b1;
    end
    else if (i_flush)
    begin
      wr_ptr  <= 3'h0;
      rd_ptr  <= 3'h0;
      o_count <= 4'h0;
      o_full  <= 1'b0;
      o_empty <= 1'b1;
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 3'h1;
      if (do_pop)
        rd_ptr <= rd_ptr + 3'h1;
      o_count <= next_count;
      o_full  <= (next_count == 4'h8);
      o_empty <= (next_count == 4'h0);
    end
  end

  // storage, no reset needed
  always_ff @(posedge i_core_clk)
  begin
    if (do_push && !i_flush)
      mem[wr_ptr] <= i_wdata;
  end
endmodule

// ### hw/sfts_top.sv
// module: spi fifo control, status, time-out and interrupt logic
`timescale 1ns/100ps
module sfts_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_rx_push,
  input  wire logic [31:0] i_rx_word,
  input  wire logic        i_tx_req,
  output logic             o_tx_ack,
  output logic [31:0]      o_tx_word,
  input  wire logic        i_unit_done,
  input  wire logic        i_slv_start,
  input  wire logic        i_three_wire,
  input  wire logic        i_master_mode,
  input  wire logic        i_sclk_tick,
  input  wire logic        i_unit_clr,
  input  wire logic        i_begin_clr,
  output logic             o_tx_full,
  output logic             o_tx_empty,
  output logic             o_rx_full,
  output logic             o_rx_empty,
  output logic             o_unit_flag,
  output logic             o_begin_flag,
  output logic             o_irq
);
  logic [31:0] fifo_control, evt_en, aw_addr, w_mask, w_data;
  logic [31:0] clr_mask, status_word, rd_word, tx_head, rx_head;
  logic [3:0]  tx_count, rx_count;
  logic [9:0]  idle_cnt, idle_limit;
  logic        wr_go, wr_hit, rd_go, rd_hit, tx_write, tx_pop, rx_pop;
  logic        idle_hit, xmit_watermark_hit, recv_watermark_hit;
  logic        idle_flag, overrun_flag, next_irq;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // byte lanes to bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction
  // address decode, shared by both channels
  function automatic logic mapped(input logic [7:0] a, input logic wr);
    case (a)
      sfts_pkg::OFF_CTL, sfts_pkg::OFF_STAT: mapped = 1'b1;
      sfts_pkg::OFF_EVT_EN:                  mapped = 1'b1;
      sfts_pkg::OFF_RXDATA, sfts_pkg::OFF_EVT: mapped = !wr;
      sfts_pkg::OFF_TXDATA, sfts_pkg::OFF_EVT_CLR: mapped = wr;
      default:                               mapped = 1'b0;
    endcase
  endfunction
  // write channel: both beats held, then one response
  assign wr_go  = !o_awready && !o_wready && !o_bvalid;
  assign wr_hit = mapped(aw_addr[7:0], 1'b1);
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= sfts_pkg::RESP_OKAY;
      aw_addr   <= 32'h00000000;
      w_data    <= 32'h00000000;
      w_mask    <= 32'h00000000;
    end
    else
    begin
      if (o_awready && i_awvalid)
      begin
        o_awready <= 1'b0;
        aw_addr   <= {24'h000000, i_awaddr};
      end
      if (o_wready && i_wvalid)
      begin
        o_wready <= 1'b0;
        w_data   <= i_wdata;
        w_mask   <= lane_mask(i_wstrb);
      end
      if (wr_go)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_hit ? sfts_pkg::RESP_OKAY : sfts_pkg::RESP_SLVERR;
      end
      else if (o_bvalid && i_bready)
      begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end
  // write side effects of this cycle
  assign tx_write = wr_go && aw_addr[7:0] == sfts_pkg::OFF_TXDATA
                    && w_mask != 32'h00000000;
  assign clr_mask = (wr_go && (aw_addr[7:0] == sfts_pkg::OFF_STAT ||
                    aw_addr[7:0] == sfts_pkg::OFF_EVT_CLR)) ?
                    (w_data & w_mask) : 32'h00000000;
  // fifo_control: fields, and flush bits that drop after one cycle
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      fifo_control <= sfts_pkg::RST_CTL;
    else
    begin
      fifo_control[sfts_pkg::CTL_TX_FLUSH] <= 1'b0;
      fifo_control[sfts_pkg::CTL_RX_FLUSH] <= 1'b0;
      if (wr_go && aw_addr[7:0] == sfts_pkg::OFF_CTL)
        fifo_control <= (fifo_control & ~(w_mask & sfts_pkg::CTL_RW_MASK))
                        | (w_data & w_mask & 32'h7720004F);
    end
  end
  // enables for unit-done and three-wire begin events
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      evt_en <= 32'h00000000;
    else if (wr_go && aw_addr[7:0] == sfts_pkg::OFF_EVT_EN)
      evt_en <= w_data & w_mask & 32'h00010800;
  end
  // the two fifos; flush acts in the cycle the bit reads as one
  sfts_fifo u_tx (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_flush    (fifo_control[sfts_pkg::CTL_TX_FLUSH]),
    .i_push     (tx_write),
    .i_wdata    (w_data),
    .i_pop      (tx_pop),
    .o_head     (tx_head),
    .o_count    (tx_count),
    .o_full     (o_tx_full),
    .o_empty    (o_tx_empty)
  );
  sfts_fifo u_rx (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_flush    (fifo_control[sfts_pkg::CTL_RX_FLUSH]),
    .i_push     (i_rx_push),
    .i_wdata    (i_rx_word),
    .i_pop      (rx_pop),
    .o_head     (rx_head),
    .o_count    (rx_count),
    .o_full     (o_rx_full),
    .o_empty    (o_rx_empty)
  );
  // shift engine takes the oldest tx word, answered next cycle
  assign tx_pop = i_tx_req && !o_tx_empty;
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_tx_ack  <= 1'b0;
      o_tx_word <= 32'h00000000;
    end
    else
    begin
      o_tx_ack <= tx_pop;
      if (tx_pop)
        o_tx_word <= tx_head;
    end
  end
  // status word: counts, mirrors, flags
  always_comb
  begin
    status_word = 32'h00000000;
    status_word[31:28] = tx_count;
    status_word[sfts_pkg::ST_TXFULL]  = o_tx_full;
    status_word[sfts_pkg::ST_TXEMPTY] = o_tx_empty;
    status_word[sfts_pkg::ST_RXFULL]  = o_rx_full;
    status_word[sfts_pkg::ST_RXEMPTY] = o_rx_empty;
    status_word[sfts_pkg::ST_TIMEOUT] = idle_flag;
    status_word[sfts_pkg::ST_UNIT]    = o_unit_flag;
    status_word[15:12] = rx_count;
    status_word[sfts_pkg::ST_BEGIN]   = o_begin_flag;
    status_word[sfts_pkg::ST_TXHIT]   = xmit_watermark_hit;
    status_word[sfts_pkg::ST_OVERRUN] = overrun_flag;
    status_word[sfts_pkg::ST_RXHIT]   = recv_watermark_hit;
  end
  // read data mux
  always_comb
  begin
    case (i_araddr)
      sfts_pkg::OFF_RXDATA: rd_word = rx_head;
      sfts_pkg::OFF_CTL:    rd_word = fifo_control;
      sfts_pkg::OFF_STAT:   rd_word = status_word;
      sfts_pkg::OFF_EVT:    rd_word = status_word & 32'h00110804;
      sfts_pkg::OFF_EVT_EN: rd_word = evt_en;
      default:              rd_word = 32'h00000000;
    endcase
  end
  // read channel; rx data read pops the fifo
  assign rd_go  = o_arready && i_arvalid;
  assign rd_hit = mapped(i_araddr, 1'b0);
  assign rx_pop = rd_go && i_araddr == sfts_pkg::OFF_RXDATA;
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= sfts_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_hit ? rd_word : 32'h00000000;
      o_rresp   <= rd_hit ? sfts_pkg::RESP_OKAY : sfts_pkg::RESP_SLVERR;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end
  // watermark flags follow counts one cycle later
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      xmit_watermark_hit <= 1'b0;
      recv_watermark_hit <= 1'b0;
    end
    else
    begin
      xmit_watermark_hit <= tx_count <= {1'b0, fifo_control[30:28]};
      recv_watermark_hit <= rx_count > {1'b0, fifo_control[26:24]};
    end
  end
  // idle timer in sclk ticks (master) or clocks (slave); fires once
  assign idle_limit = i_master_mode ? sfts_pkg::TO_MASTER_SCLK
                                    : sfts_pkg::TO_SLAVE_CLK;
  assign idle_hit = !o_rx_empty && !rx_pop && idle_cnt == idle_limit
                    && (i_sclk_tick || !i_master_mode);
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      idle_cnt <= 10'h000;
    else if (o_rx_empty || rx_pop)
      idle_cnt <= 10'h000;
    else if ((i_sclk_tick || !i_master_mode) && idle_cnt <= idle_limit)
      idle_cnt <= idle_cnt + 10'h001;
  end
  // sticky event flags; a set wins over a clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      idle_flag    <= 1'b0;
      overrun_flag <= 1'b0;
      o_unit_flag  <= 1'b0;
      o_begin_flag <= 1'b0;
    end
    else
    begin
      if (idle_hit)
        idle_flag <= 1'b1;
      else if (rx_pop || clr_mask[sfts_pkg::ST_TIMEOUT])
        idle_flag <= 1'b0;
      if (i_rx_push && o_rx_full)
        overrun_flag <= 1'b1;
      else if (clr_mask[sfts_pkg::ST_OVERRUN])
        overrun_flag <= 1'b0;
      if (i_unit_done)
        o_unit_flag <= 1'b1;
      else if (clr_mask[sfts_pkg::ST_UNIT] || i_unit_clr)
        o_unit_flag <= 1'b0;
      if (i_slv_start && i_three_wire)
        o_begin_flag <= 1'b1;
      else if (i_unit_done || clr_mask[sfts_pkg::ST_BEGIN] || i_begin_clr)
        o_begin_flag <= 1'b0;
    end
  end
  // one level interrupt from all enabled sources
  assign next_irq =
      (xmit_watermark_hit && fifo_control[sfts_pkg::CTL_TX_EN])
    | (recv_watermark_hit && fifo_control[sfts_pkg::CTL_RX_EN])
    | (idle_flag && fifo_control[sfts_pkg::CTL_TO_EN])
    | (overrun_flag && fifo_control[sfts_pkg::CTL_OV_EN])
    | (o_unit_flag && evt_en[sfts_pkg::ST_UNIT])
    | (o_begin_flag && evt_en[sfts_pkg::ST_BEGIN]);
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_irq <= 1'b0;
    else
      o_irq <= next_irq;
  end

  // checks on the watermark flags
  property p_tx_mark;
    $past(i_nrst) |-> xmit_watermark_hit ==
      ($past(tx_count) <= {1'b0, $past(fifo_control[30:28])});
  endproperty
  a_tx_mark: assert property (p_tx_mark) else $error("tx mark wrong");
  property p_rx_mark;
    $changed(rx_count) |=> recv_watermark_hit ==
      ($past(rx_count) > {1'b0, $past(fifo_control[26:24])});
  endproperty
  a_rx_mark: assert property (p_rx_mark) else $error("rx mark wrong");
  // checks on the tx and rx watermark interrupt paths
  property p_tx_irq;
    xmit_watermark_hit && fifo_control[sfts_pkg::CTL_TX_EN] |=> o_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx irq lost");
  property p_rx_irq;
    recv_watermark_hit && fifo_control[sfts_pkg::CTL_RX_EN] |=> o_irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq lost");

  // time-out only with data and after the full idle_limit wait of the current mode
  property p_idle_set;
    $rose(idle_flag) |-> !$past(o_rx_empty) && $past(idle_cnt) == idle_limit;
  endproperty
  a_idle_set: assert property (p_idle_set) else $error("bad idle");
  property p_idle_clr;
    rx_pop |=> !idle_flag;
  endproperty
  a_idle_clr: assert property (p_idle_clr) else $error("idle stuck");

  // overrun and ignored tx writes
  property p_overrun;
    i_rx_push && o_rx_full && !fifo_control[sfts_pkg::CTL_RX_FLUSH]
      |=> overrun_flag && rx_count == $past(rx_count) - {3'h0, $past(rx_pop)};
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun miss");
  property p_tx_full;
    tx_write && o_tx_full && !tx_pop && !fifo_control[sfts_pkg::CTL_TX_FLUSH]
      |=> $stable(tx_count);
  endproperty
  a_tx_full: assert property (p_tx_full) else $error("tx overfill");

  // flush takes one cycle to arm and one to empty
  sequence s_tx_flush_wr;
    wr_go && aw_addr[7:0] == sfts_pkg::OFF_CTL && w_mask[0] && w_data[1];
  endsequence
  sequence s_tx_emptied;
    fifo_control[sfts_pkg::CTL_TX_FLUSH] ##1
      !fifo_control[sfts_pkg::CTL_TX_FLUSH] && tx_count == 4'h0 && o_tx_empty;
  endsequence
  property p_tx_flush;
    s_tx_flush_wr |=> s_tx_emptied;
  endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("flush fail");

  // begin flag follows the three-wire start
  property p_begin;
    i_slv_start && i_three_wire |=> o_begin_flag;
  endproperty
  a_begin: assert property (p_begin) else $error("begin lost");
endmodule

// ### tb/sfts_engine_model.sv
// module: behavioural shift engine that fills and drains the fifos
`timescale 1ns/100ps
module sfts_engine_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_tx_ack,
  input  wire logic [31:0] i_tx_word,
  output logic             o_rx_push,
  output logic [31:0]      o_rx_word,
  output logic             o_tx_req,
  output logic             o_unit_done,
  output logic             o_slv_start,
  output logic             o_sclk_tick
);
  // idle levels at time zero
  initial
  begin
    {o_rx_push, o_tx_req, o_unit_done, o_slv_start, o_sclk_tick} = 5'h00;
    o_rx_word = 32'h00000000;
  end
  // one word in; released data line shows the inverse, gap slows it
  task automatic push(input logic [31:0] v, input int gap);
    @(posedge i_core_clk);
    o_rx_push <= 1'h1;
    o_rx_word <= v;
    @(posedge i_core_clk);
    o_rx_push <= 1'h0;
    o_rx_word <= ~v;
    repeat (gap) @(posedge i_core_clk);
  endtask
  // take one word to shift out; software loads it before any go
  task automatic pop(output logic [31:0] v, output logic ack);
    @(posedge i_core_clk);
    o_tx_req <= 1'h1;
    @(posedge i_core_clk);
    o_tx_req <= 1'h0;
    @(posedge i_core_clk);
    ack = i_tx_ack;
    v = i_tx_word;
  endtask
  // one cycle strobe: 0 unit done, 1 slave start, else sclk tick
  task automatic strobe(input int k);
    @(posedge i_core_clk);
    case (k)
      0: o_unit_done <= 1'h1;
      1: o_slv_start <= 1'h1;
      default: o_sclk_tick <= 1'h1;
    endcase
    @(posedge i_core_clk);
    o_unit_done <= 1'h0;
    o_slv_start <= 1'h0;
    o_sclk_tick <= 1'h0;
  endtask
endmodule

// ### tb/test_sfts_top.sv
// testbench: registers, fifos, time-out and event flags of the block
`timescale 1ns/100ps
// compare and count, report a mismatch at once
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
  end
module test_sfts_top;
  logic        core_clk, nrst, ack;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, tx_ack;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  r, bresp, rresp;
  logic [31:0] wdata, d, w, rdata, tx_word, rx_word;
  logic        three_wire, master_mode, unit_clr, begin_clr;
  logic        tx_full, tx_empty, rx_full, rx_empty, unit_flag;
  logic        begin_flag, irq, rx_push, tx_req, unit_done;
  logic        slv_start, sclk_tick;
  int          err_total = 0;
  int          checked = 0;
  sfts_top i_sfts_top (
    .i_core_clk(core_clk), .i_nrst(nrst), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .i_rx_push(rx_push), .i_rx_word(rx_word),
    .i_tx_req(tx_req), .o_tx_ack(tx_ack), .o_tx_word(tx_word),
    .i_unit_done(unit_done), .i_slv_start(slv_start),
    .i_three_wire(three_wire), .i_master_mode(master_mode),
    .i_sclk_tick(sclk_tick), .i_unit_clr(unit_clr),
    .i_begin_clr(begin_clr), .o_tx_full(tx_full),
    .o_tx_empty(tx_empty), .o_rx_full(rx_full),
    .o_rx_empty(rx_empty), .o_unit_flag(unit_flag),
    .o_begin_flag(begin_flag), .o_irq(irq)
  );
  sfts_engine_model i_sfts_engine_model (
    .i_core_clk(core_clk), .i_tx_ack(tx_ack), .i_tx_word(tx_word),
    .o_rx_push(rx_push), .o_rx_word(rx_word), .o_tx_req(tx_req),
    .o_unit_done(unit_done), .o_slv_start(slv_start),
    .o_sclk_tick(sclk_tick)
  );
  // 200 MHz clock
  initial
  begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  // hang guard, far beyond the thousand or so cycles the run needs
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    end_sim();
  end
  task automatic end_sim();
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // bus write, each channel held until taken; response left in r
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata <= v;
    forever
    begin
      @(posedge core_clk);
      if (awvalid && awready)
        awvalid <= 1'h0;
      if (wvalid && wready)
        wvalid <= 1'h0;
      if (bvalid === 1'h1)
        break;
    end
    bready <= 1'h0;
    r = bresp;
  endtask
  // bus read; data in d, response in r
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    forever
    begin
      @(posedge core_clk);
      if (arvalid && arready)
        arvalid <= 1'h0;
      if (rvalid === 1'h1)
        break;
    end
    rready <= 1'h0;
    d = rdata;
    r = rresp;
  endtask
  // reset values and unmapped accesses
  task automatic t_reset();
    rd(sfts_pkg::OFF_CTL);
    `CHK("ctl", sfts_pkg::RST_CTL, d)
    rd(sfts_pkg::OFF_STAT);
    `CHK("stat", sfts_pkg::RST_STAT | 32'h00000010, d)
    rd(8'h7C);
    `CHK("bad_r", sfts_pkg::RESP_SLVERR, r)
    `CHK("bad_d", 32'h00000000, d)
    wr(8'h7C, 32'hFFFFFFFF);
    `CHK("bad_w", sfts_pkg::RESP_SLVERR, r)
  endtask
  // tx fill past full, watermark edge at 7, pop order, flush
  task automatic t_tx();
    wr(sfts_pkg::OFF_CTL, 32'h73000008);
    cyc(3);
    `CHK("irq_tx", 1'h1, irq)
    for (int i = 0; i < 9; i++)
      wr(sfts_pkg::OFF_TXDATA, 32'hA0 + i);
    rd(sfts_pkg::OFF_STAT);
    `CHK("txst", 7'h44, {d[31:26], d[4]})
    `CHK("txfo", 1'h1, tx_full)
    `CHK("irq_8", 1'h0, irq)
    i_sfts_engine_model.pop(w, ack);
    `CHK("pop", 33'h1000000A0, {ack, w})
    cyc(3);
    `CHK("irq_7", 1'h1, irq)
    wr(sfts_pkg::OFF_CTL, 32'h7300000A);
    cyc(2);
    `CHK("txeo", 1'h1, tx_empty)
    rd(sfts_pkg::OFF_STAT);
    `CHK("txcl", 6'h01, d[31:26])
    wstrb <= ~wstrb;
    wr(sfts_pkg::OFF_TXDATA, 32'h000000AF);
    wstrb <= ~wstrb;
    rd(sfts_pkg::OFF_STAT);
    `CHK("txnos", 6'h01, d[31:26])
    rd(sfts_pkg::OFF_CTL);
    `CHK("ctl_tx", 32'h73000008, d)
  endtask
  // rx fill with overrun, threshold edge at 3, read order, flush
  task automatic t_rx();
    wr(sfts_pkg::OFF_CTL, 32'h03000044);
    for (int i = 0; i < 9; i++)
    begin
      i_sfts_engine_model.push(32'hB0 + i, i % 2);
      if (i == 2 || i == 3)
      begin
        rd(sfts_pkg::OFF_STAT);
        `CHK("rxhit", (i == 3), d[0])
        `CHK("irq_rx", (i == 3), irq)
      end
    end
    rd(sfts_pkg::OFF_STAT);
    `CHK("rxst", 7'h45, {d[15:12], d[25:24], d[2]})
    `CHK("rxfo", 1'h1, rx_full)
    rd(sfts_pkg::OFF_RXDATA);
    `CHK("rxd", 32'h000000B0, d)
    rd(sfts_pkg::OFF_RXDATA);
    `CHK("rxd2", 32'h000000B1, d)
    rd(sfts_pkg::OFF_STAT);
    `CHK("rxcnt", 4'h6, d[15:12])
    wr(sfts_pkg::OFF_CTL, 32'h03000040);
    cyc(3);
    `CHK("irq_ov", 1'h1, irq)
    wr(sfts_pkg::OFF_STAT, 32'h00000004);
    cyc(3);
    `CHK("irq_ovc", 1'h0, irq)
    wr(sfts_pkg::OFF_CTL, 32'h03000001);
    cyc(2);
    `CHK("rxeo", 1'h1, rx_empty)
    rd(sfts_pkg::OFF_STAT);
    `CHK("rxcl", 7'h02, {d[15:12], d[25:24], d[2]})
  endtask
  // idle time-out, slave core clocks then master ticks, both clears
  task automatic t_idle();
    wr(sfts_pkg::OFF_CTL, 32'h00200000);
    i_sfts_engine_model.push(32'hC0, 0);
    cyc(560);
    rd(sfts_pkg::OFF_STAT);
    `CHK("to_lo", 1'h0, d[20])
    cyc(20);
    rd(sfts_pkg::OFF_STAT);
    `CHK("to_hi", 1'h1, d[20])
    `CHK("irq_to", 1'h1, irq)
    wr(sfts_pkg::OFF_CTL, 32'h00000000);
    cyc(3);
    `CHK("irq_ton", 1'h0, irq)
    rd(sfts_pkg::OFF_RXDATA);
    rd(sfts_pkg::OFF_STAT);
    `CHK("to_rd", 1'h0, d[20])
    master_mode <= 1'h1;
    i_sfts_engine_model.push(32'hC1, 0);
    repeat (63) i_sfts_engine_model.strobe(2);
    rd(sfts_pkg::OFF_STAT);
    `CHK("tom_lo", 1'h0, d[20])
    repeat (2) i_sfts_engine_model.strobe(2);
    rd(sfts_pkg::OFF_STAT);
    `CHK("tom_hi", 1'h1, d[20])
    wr(sfts_pkg::OFF_STAT, 32'h00100000);
    rd(sfts_pkg::OFF_STAT);
    `CHK("to_w1c", 1'h0, d[20])
    wr(sfts_pkg::OFF_CTL, 32'h00000001);
    master_mode <= 1'h0;
  endtask
  // unit done and three-wire begin flags, clears and enable
  task automatic t_evt();
    wr(sfts_pkg::OFF_EVT_EN, 32'h00010000);
    i_sfts_engine_model.strobe(0);
    cyc(2);
    `CHK("unit", 2'h3, {unit_flag, irq})
    rd(sfts_pkg::OFF_EVT);
    `CHK("evt", 32'h00010000, d)
    wr(sfts_pkg::OFF_STAT, 32'h00010000);
    cyc(2);
    `CHK("unit_c", 1'h0, unit_flag)
    three_wire <= 1'h1;
    i_sfts_engine_model.strobe(1);
    rd(sfts_pkg::OFF_STAT);
    `CHK("beg", 1'h1, d[11])
    i_sfts_engine_model.strobe(0);
    cyc(2);
    `CHK("beg_d", 2'h1, {begin_flag, unit_flag})
    unit_clr <= 1'h1;
    cyc(1);
    unit_clr <= 1'h0;
    i_sfts_engine_model.strobe(1);
    cyc(2);
    `CHK("beg_m", 2'h2, {begin_flag, unit_flag})
    begin_clr <= 1'h1;
    cyc(1);
    begin_clr <= 1'h0;
    cyc(2);
    `CHK("beg_c", 1'h0, begin_flag)
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    nrst = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    {three_wire, master_mode, unit_clr, begin_clr} = 4'h0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'h1;
    t_reset();
    t_tx();
    t_rx();
    t_idle();
    t_evt();
    end_sim();
  end
endmodule
